// ### verilog/uart_int_defs.svh
// Function
// - FIFO on and receive enabled: receive interrupt while fill is at or above trigger.
// - Data ready flag sets when a character enters the FIFO, clears when empty.
// - FIFO on with mask bits 3:0 zero gives polled mode, except Xon and special character still interrupt; flags still readable.
// - Line status bit 1 overrun, bits 4:2 top-byte errors, bit 7 any FIFO error.
// - Line status bit 5 holding or FIFO empty, bit 6 FIFO and shifter empty.
// - Mask bit 7 enables interrupt on CTS rising; writable only with enhanced bit 4.
// - Mask bit 6 enables interrupt on RTS rising; also gated by enhanced bit 4.
// - Mask bit 5 enables Xoff interrupt; mask bit 4 is reserved.
// - Mask bit 3 enables modem status interrupt on any delta bit set.
// - Mask bit 2: error raises line interrupt; re-raised when errored byte reaches top.
// - Mask bit 1: transmit interrupt on empty, or below trigger and again on empty.
// - Mask bit 0: receive interrupt on holding full, or FIFO at trigger level.
// - Reset clears every mask bit.
// - Source read returns only the highest pending source; others stay queued, except transmit, Xon/Xoff and special character, which it clears.
// - Source codes 06,04,0C,02,00,10,20 by priority; 01 when none pending.
// - Time-out interrupt after four characters plus twelve bits with data below trigger.
// - Flow pin interrupts need auto flow enables; modem control bit 2 picks pins.
// - Wake-up indication sets on leaving sleep, clears on global register read.
// - Line status read clears line interrupt; modem status read clears pin; modem clears when MSR_DELTA is zero.
// - Receive interrupt clears below trigger; time-out clears on holding read.
// - Transmit clears on source read or holding write; Xon/Xoff on source read.
// - Source bits 7:6 read one while FIFOs enabled, zero otherwise.
// - Source bit 0 is zero while pending, one when idle, one at reset.
// - FIFO enable bit selects FIFO mode for the receive, time-out and transmit conditions.
`ifndef UART_INT_DEFS_SVH
`define UART_INT_DEFS_SVH

`define MASK_RESET       8'h00
`define MASK_RX_BIT      0
`define MASK_TX_BIT      1
`define MASK_LINE_BIT    2
`define MASK_MODEM_BIT   3
`define MASK_XOFF_BIT    5
`define MASK_RTS_BIT     6
`define MASK_CTS_BIT     7
`define MASK_ENH_BITS    8'hE0
`define SRC_LINE         6'h06
`define SRC_RX_READY_EVENT        6'h04
`define SRC_TIMEOUT      6'h0C
`define SRC_TX_READY_EVENT        6'h02
`define SRC_MODEM        6'h00
`define SRC_XCHAR        6'h10
`define SRC_PIN          6'h20
`define SRC_NONE         6'h01
`define SRC_RESET        8'h01
`define TIMEOUT_CHARS    4
`define TIMEOUT_BITS     12
`define CLK_NS           20

`endif

// ### verilog/uart_int_pkg.sv
package uart_int_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [7:0] {
    SRC_LINE_E  = 8'h01,
    SRC_RX_READY_EVENT_E = 8'h02,
    SRC_TOUT_E  = 8'h04,
    SRC_TX_E    = 8'h08,
    SRC_MODEM_E = 8'h10,
    SRC_XCHAR_E = 8'h20,
    SRC_PIN_E   = 8'h40,
    SRC_IDLE_E  = 8'h80
  } src_e;
endpackage : uart_int_pkg

// ### verilog/rise_latch.sv
`timescale 1ns/100ps
`default_nettype none
module rise_latch (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Event and clear.
  input  wire logic level,
  input  wire logic clr,
  output logic      flag
);
  logic prev_q;
  logic prev_d;
  logic flag_q;
  logic flag_d;

  always_comb begin
    prev_d = level;
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    if (level && !prev_q) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b1;
      flag_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;
endmodule // rise_latch
`default_nettype wire

// ### verilog/uart_channel_interrupt_logic.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_defs.svh"
module uart_channel_interrupt_logic #(
  parameter int FIFO_DEPTH = 64,
  parameter int CNT_W      = 7,
  parameter int TMR_W      = 24
) (
  // Clock and reset.
  input  wire logic                 SYS_CLK,
  input  wire logic                 RESET,
  // Mask register port.
  input  wire logic                 MASK_WR,
  input  wire uart_int_pkg::reg8_t  MASK_WDATA,
  output uart_int_pkg::reg8_t       MASK_RDATA,
  // Read and write strobes from the register decoder.
  input  wire logic                 SRC_RD,
  input  wire logic                 LSR_RD,
  input  wire logic                 MSR_RD,
  input  wire logic                 RHR_RD,
  input  wire logic                 THR_WR,
  input  wire logic                 GLOBAL_RD,
  // Configuration.
  input  wire logic                 FIFO_EN,
  input  wire logic                 ENH_EN,
  input  wire logic                 AUTO_CTS_EN,
  input  wire logic                 AUTO_RTS_EN,
  input  wire logic                 PIN_SEL_DTR,
  input  wire logic                 HALF_DUPLEX_EN,
  input  wire logic [CNT_W-1:0]     RX_TRIGGER,
  input  wire logic [CNT_W-1:0]     TX_TRIGGER,
  input  wire logic [TMR_W-1:0]     BIT_CYCLES,
  input  wire logic [3:0]           CHAR_BITS,
  // Receive and transmit state.
  input  wire logic [CNT_W-1:0]     RX_COUNT,
  input  wire logic [CNT_W-1:0]     TX_COUNT,
  input  wire logic                 RX_PUSH,
  input  wire logic                 RX_PUSH_ERR,
  input  wire logic                 RX_OVERRUN,
  input  wire logic [2:0]           RX_TOP_ERR,
  input  wire logic                 RX_FIFO_ERR,
  input  wire logic                 RX_HOLD_FULL,
  input  wire logic                 TX_HOLD_EMPTY,
  input  wire logic                 TX_SHIFT_EMPTY,
  // Modem, flow and sleep events.
  input  wire logic [3:0]           MSR_DELTA,
  input  wire logic                 XON_DET,
  input  wire logic                 XOFF_DET,
  input  wire logic                 SPECIAL_DET,
  input  wire logic                 CTS_PIN,
  input  wire logic                 DSR_PIN,
  input  wire logic                 RTS_PIN,
  input  wire logic                 DTR_PIN,
  input  wire logic                 WAKE_EVENT,
  // Results.
  output uart_int_pkg::reg8_t       SRC_RDATA,
  output uart_int_pkg::reg8_t       LINE_STATUS,
  output logic                      WAKE_IND,
  output logic                      IRQ
);
  import uart_int_pkg::*;

  // ****************************************************************
  // Time-out length.
  // ****************************************************************
  localparam int TOUT_BITS_MULT = `TIMEOUT_CHARS;

  reg8_t            mask_q, mask_d;
  logic             line_q, line_d;
  logic             top_err_q, top_err_d;
  logic             tout_q, tout_d;
  logic             tx_q, tx_d;
  logic             tx_empty_armed_q, tx_empty_armed_d;
  logic             tx_above_q, tx_above_d;
  logic             xon_q, xon_d;
  logic             xoff_q, xoff_d;
  logic             spec_q, spec_d;
  logic             wake_q, wake_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] tmr_limit;
  reg8_t            src_q, src_d;
  reg8_t            lsr_q, lsr_d;
  logic             irq_q, irq_d;
  logic             cts_flag, rts_flag;
  logic             rx_at_trig, rx_ready_src, pin_src, modem_src;
  logic             tx_empty_now;
  src_e             win;

  // ****************************************************************
  // Flow pin edge latches.
  // ****************************************************************
  // Pin pair select
  rise_latch u_cts (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .level (PIN_SEL_DTR ? DSR_PIN : CTS_PIN),
    .clr   (MSR_RD),
    .flag  (cts_flag)
  );
  rise_latch u_rts (
    .clk   (SYS_CLK),
    .rst   (RESET),
    .level (PIN_SEL_DTR ? DTR_PIN : RTS_PIN),
    .clr   (MSR_RD),
    .flag  (rts_flag)
  );

  // ****************************************************************
  // Pending sources.
  // ****************************************************************
  always_comb begin
    tmr_limit = TMR_W'((TOUT_BITS_MULT * int'(CHAR_BITS) + `TIMEOUT_BITS) * int'(BIT_CYCLES));
    rx_at_trig = FIFO_EN ? (RX_COUNT >= RX_TRIGGER) : RX_HOLD_FULL;
    rx_ready_src = mask_q[`MASK_RX_BIT] && rx_at_trig;
    pin_src = (mask_q[`MASK_CTS_BIT] && AUTO_CTS_EN && cts_flag) ||
              (mask_q[`MASK_RTS_BIT] && AUTO_RTS_EN && rts_flag);
    modem_src = mask_q[`MASK_MODEM_BIT] && (MSR_DELTA != 4'h0);
    tx_empty_now = HALF_DUPLEX_EN ? (TX_HOLD_EMPTY && TX_SHIFT_EMPTY) : TX_HOLD_EMPTY;
  end

  always_comb begin
    mask_d           = mask_q;
    line_d           = line_q;
    top_err_d        = RX_TOP_ERR != 3'h0;
    tout_d           = tout_q;
    tx_d             = tx_q;
    tx_empty_armed_d = tx_empty_armed_q;
    tx_above_d       = tx_above_q;
    xon_d            = xon_q;
    xoff_d           = xoff_q;
    spec_d           = spec_q;
    wake_d           = wake_q;
    tmr_d            = tmr_q;
    if (MASK_WR) begin
      mask_d = ENH_EN ? MASK_WDATA : ((MASK_WDATA & ~`MASK_ENH_BITS) | (mask_q & `MASK_ENH_BITS));
      mask_d[4] = 1'b0;
    end
    if (LSR_RD) begin
      line_d = 1'b0;
    end
    if ((RX_PUSH && RX_PUSH_ERR) || RX_OVERRUN || ((RX_TOP_ERR != 3'h0) && !top_err_q)) begin
      line_d = 1'b1;
    end
    if (RHR_RD || !FIFO_EN || RX_COUNT == '0 || rx_at_trig) begin
      tmr_d  = '0;
      tout_d = tout_q && !RHR_RD && FIFO_EN && RX_COUNT != '0;
    end else if (RX_PUSH) begin
      tmr_d = '0;
    end else if (tmr_q >= tmr_limit) begin
      tout_d = 1'b1;
    end else begin
      tmr_d = tmr_q + 1'b1;
    end
    if (SRC_RD || THR_WR) begin
      tx_d = 1'b0;
    end
    if (TX_COUNT >= TX_TRIGGER) begin
      tx_above_d = 1'b1;
    end
    if (!FIFO_EN) begin
      if (tx_empty_now && !tx_empty_armed_q) begin
        tx_d = 1'b1;
      end
      tx_empty_armed_d = tx_empty_now;
    end else begin
      if (tx_above_q && TX_COUNT < TX_TRIGGER) begin
        tx_d       = 1'b1;
        tx_above_d = 1'b0;
      end
      if (tx_empty_now && !tx_empty_armed_q) begin
        tx_d = 1'b1;
      end
      tx_empty_armed_d = tx_empty_now;
    end
    if (SRC_RD) begin
      xon_d  = 1'b0;
      xoff_d = 1'b0;
      spec_d = 1'b0;
    end
    if (RX_PUSH) begin
      spec_d = 1'b0;
    end
    if (XON_DET) begin
      xon_d = 1'b1;
    end
    if (XOFF_DET) begin
      xoff_d = 1'b1;
    end
    if (SPECIAL_DET) begin
      spec_d = 1'b1;
    end
    if (GLOBAL_RD) begin
      wake_d = 1'b0;
    end
    if (WAKE_EVENT) begin
      wake_d = 1'b1;
    end
  end

  // ****************************************************************
  // Priority encoder and status.
  // ****************************************************************
  always_comb begin
    if (mask_q[`MASK_LINE_BIT] && line_q) begin
      win = SRC_LINE_E;
    end else if (rx_ready_src) begin
      win = SRC_RX_READY_EVENT_E;
    end else if (mask_q[`MASK_RX_BIT] && tout_q) begin
      win = SRC_TOUT_E;
    end else if (mask_q[`MASK_TX_BIT] && tx_q) begin
      win = SRC_TX_E;
    end else if (modem_src) begin
      win = SRC_MODEM_E;
    end else if ((mask_q[`MASK_XOFF_BIT] && xoff_q) || xon_q || spec_q) begin
      win = SRC_XCHAR_E;
    end else if (pin_src) begin
      win = SRC_PIN_E;
    end else begin
      win = SRC_IDLE_E;
    end
    src_d = 8'h00;
    unique case (win)
      SRC_LINE_E:  src_d[5:0] = `SRC_LINE;
      SRC_RX_READY_EVENT_E: src_d[5:0] = `SRC_RX_READY_EVENT;
      SRC_TOUT_E:  src_d[5:0] = `SRC_TIMEOUT;
      SRC_TX_E:    src_d[5:0] = `SRC_TX_READY_EVENT;
      SRC_MODEM_E: src_d[5:0] = `SRC_MODEM;
      SRC_XCHAR_E: src_d[5:0] = `SRC_XCHAR;
      SRC_PIN_E:   src_d[5:0] = `SRC_PIN;
      SRC_IDLE_E:  src_d[5:0] = `SRC_NONE;
    endcase
    src_d[7:6] = {FIFO_EN, FIFO_EN};
    irq_d = win != SRC_IDLE_E;
    lsr_d[0] = FIFO_EN ? (RX_COUNT != '0) : RX_HOLD_FULL;
    lsr_d[1] = line_q && RX_OVERRUN ? 1'b1 : RX_OVERRUN;
    lsr_d[4:2] = RX_TOP_ERR;
    lsr_d[5] = FIFO_EN ? (TX_COUNT == '0) : TX_HOLD_EMPTY;
    lsr_d[6] = (FIFO_EN ? (TX_COUNT == '0) : TX_HOLD_EMPTY) && TX_SHIFT_EMPTY;
    lsr_d[7] = RX_FIFO_ERR && FIFO_EN;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mask_q           <= `MASK_RESET;
      line_q           <= 1'b0;
      top_err_q        <= 1'b0;
      tout_q           <= 1'b0;
      tx_q             <= 1'b0;
      tx_empty_armed_q <= 1'b0;
      tx_above_q       <= 1'b0;
      xon_q            <= 1'b0;
      xoff_q           <= 1'b0;
      spec_q           <= 1'b0;
      wake_q           <= 1'b0;
      tmr_q            <= '0;
      src_q            <= `SRC_RESET;
      lsr_q            <= 8'h00;
      irq_q            <= 1'b0;
    end else begin
      mask_q           <= mask_d;
      line_q           <= line_d;
      top_err_q        <= top_err_d;
      tout_q           <= tout_d;
      tx_q             <= tx_d;
      tx_empty_armed_q <= tx_empty_armed_d;
      tx_above_q       <= tx_above_d;
      xon_q            <= xon_d;
      xoff_q           <= xoff_d;
      spec_q           <= spec_d;
      wake_q           <= wake_d;
      tmr_q            <= tmr_d;
      src_q            <= src_d;
      lsr_q            <= lsr_d;
      irq_q            <= irq_d;
    end
  end

  assign MASK_RDATA  = mask_q;
  assign SRC_RDATA   = src_q;
  assign LINE_STATUS = lsr_q;
  assign WAKE_IND    = wake_q;
  assign IRQ         = irq_q;
endmodule // uart_channel_interrupt_logic
`default_nettype wire

// ### verification/uart_int_props.sv
`timescale 1ns/100ps
`default_nettype none
// ***********************************
// Checker on the channel ports.
// ***********************************
module uart_int_props (
  // Clock and reset.
  input wire logic                SYS_CLK,
  input wire logic                RESET,
  // Inputs watched.
  input wire logic                MASK_WR,
  input wire uart_int_pkg::reg8_t MASK_WDATA,
  input wire logic                ENH_EN,
  input wire logic                FIFO_EN,
  input wire logic                RX_PUSH,
  input wire logic [2:0]          RX_TOP_ERR,
  input wire logic                RX_FIFO_ERR,
  input wire logic                TX_HOLD_EMPTY,
  input wire logic                TX_SHIFT_EMPTY,
  input wire logic [6:0]          TX_COUNT,
  input wire logic [3:0]          MSR_DELTA,
  input wire logic                MSR_RD,
  input wire logic                XOFF_DET,
  input wire logic                WAKE_EVENT,
  input wire logic                GLOBAL_RD,
  // Outputs watched.
  input wire uart_int_pkg::reg8_t MASK_RDATA,
  input wire uart_int_pkg::reg8_t SRC_RDATA,
  input wire uart_int_pkg::reg8_t LINE_STATUS,
  input wire logic                WAKE_IND,
  input wire logic                IRQ
);
  import uart_int_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  mask_reset_a: assert property (disable iff (1'h0) RESET |=> MASK_RDATA == 8'h00 && SRC_RDATA == 8'h01)
    else $error("mask or source wrong after reset");
  mask_write_a: assert property (MASK_WR && ENH_EN |=> MASK_RDATA == ($past(MASK_WDATA) & 8'hEF))
    else $error("mask write lost");
  enh_gate_a: assert property (MASK_WR && !ENH_EN |=> MASK_RDATA[7:5] == $past(MASK_RDATA[7:5])
    && MASK_RDATA[3:0] == $past(MASK_WDATA[3:0])) else $error("gated mask bits changed");
  fifo_bits_a: assert property (!$past(RESET) && $stable(FIFO_EN) |-> SRC_RDATA[7:6] == {2{FIFO_EN}})
    else $error("source bits 7:6 wrong");
  idle_code_a: assert property (SRC_RDATA[0] |-> SRC_RDATA[5:1] == 5'h00)
    else $error("idle code malformed");
  irq_code_a: assert property (IRQ == !SRC_RDATA[0])
    else $error("irq disagrees with source");
  code_set_a: assert property (SRC_RDATA[5:0] inside {6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01})
    else $error("illegal source code");
  xoff_raise_a: assert property (XOFF_DET && MASK_RDATA[5] |-> ##2 IRQ)
    else $error("xoff did not raise irq");
  modem_raise_a: assert property ($rose(|MSR_DELTA) && MASK_RDATA[3] && !MSR_RD |-> ##[1:2] IRQ)
    else $error("modem delta did not raise irq");
  data_ready_a: assert property (RX_PUSH |=> LINE_STATUS[0])
    else $error("data ready not set");
  rx_err_a: assert property (!$past(RESET) |-> LINE_STATUS[7] == $past(RX_FIFO_ERR && FIFO_EN)
    && LINE_STATUS[4:2] == $past(RX_TOP_ERR)) else $error("receive error bits wrong");
  tx_empty_a: assert property (!$past(RESET) |-> LINE_STATUS[6] == (LINE_STATUS[5] && $past(TX_SHIFT_EMPTY))
    && LINE_STATUS[5] == ($past(FIFO_EN) ? ($past(TX_COUNT) == 7'h00) : $past(TX_HOLD_EMPTY)))
    else $error("empty bits wrong");
  wake_set_a: assert property (WAKE_EVENT |=> WAKE_IND)
    else $error("wake not flagged");
  wake_clr_a: assert property (GLOBAL_RD && !WAKE_EVENT |=> !WAKE_IND)
    else $error("wake not cleared");
endmodule // uart_int_props
`default_nettype wire

// ### verification/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***********************************
// Host issuing register strobes.
// ***********************************
module host_bus_model (
  // Clock.
  input  wire logic          SYS_CLK,
  // Strobes toward the channel.
  output logic               MASK_WR,
  output uart_int_pkg::reg8_t MASK_WDATA,
  output logic               SRC_RD,
  output logic               LSR_RD,
  output logic               MSR_RD,
  output logic               RHR_RD,
  output logic               THR_WR,
  output logic               GLOBAL_RD
);
  import uart_int_pkg::*;
  logic [6:0] stb_q = 7'h00;
  assign {GLOBAL_RD, THR_WR, RHR_RD, MSR_RD, LSR_RD, SRC_RD, MASK_WR} = stb_q;
  initial MASK_WDATA = 8'h00;
  task automatic acc(input int k, input reg8_t d);
    @(posedge SYS_CLK);
    stb_q <= 7'h01 << k;
    MASK_WDATA <= d;
    @(posedge SYS_CLK);
    stb_q <= 7'h00;
  endtask
endmodule // host_bus_model
`default_nettype wire

// ### verification/uart_channel_interrupt_logic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_defs.svh"
// ***********************************
// Bench top.
// ***********************************
module uart_channel_interrupt_logic_tb_top;
  import uart_int_pkg::*;
  logic SYS_CLK = 1'h0, RESET = 1'h1, FIFO_EN = 1'h0, ENH_EN = 1'h0, AUTO_CTS_EN = 1'h1;
  logic AUTO_RTS_EN = 1'h0, PIN_SEL_DTR = 1'h0, HALF_DUPLEX_EN = 1'h0, RX_PUSH = 1'h0;
  logic RX_PUSH_ERR = 1'h0, RX_OVERRUN = 1'h0, RX_FIFO_ERR = 1'h0, RX_HOLD_FULL = 1'h0;
  logic TX_HOLD_EMPTY = 1'h0, TX_SHIFT_EMPTY = 1'h0, XON_DET = 1'h0, XOFF_DET = 1'h0;
  logic SPECIAL_DET = 1'h0, CTS_PIN = 1'h0, DSR_PIN = 1'h0, RTS_PIN = 1'h0, DTR_PIN = 1'h0;
  logic WAKE_EVENT = 1'h0;
  logic [6:0] RX_TRIGGER = 7'h08, TX_TRIGGER = 7'h04, RX_COUNT = 7'h00, TX_COUNT = 7'h04;
  logic [23:0] BIT_CYCLES = 24'h000002;
  logic [3:0] CHAR_BITS = 4'h4, MSR_DELTA = 4'h0;
  logic [2:0] RX_TOP_ERR = 3'h0;
  wire logic MASK_WR, SRC_RD, LSR_RD, MSR_RD, RHR_RD, THR_WR, GLOBAL_RD;
  wire reg8_t MASK_WDATA;
  reg8_t MASK_RDATA, SRC_RDATA, LINE_STATUS, r, m;
  logic WAKE_IND, IRQ;
  int mismatches = 0, n_checks = 0, cyc = 0, tmo;
  reg8_t masks [6] = '{8'h01, 8'h08, 8'h20, 8'h80, 8'h00, 8'h40};
  always #10 SYS_CLK = ~SYS_CLK;
  uart_channel_interrupt_logic DUT (.*);
  host_bus_model HOST (.*);
  task automatic step(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask
  task automatic chk(input reg8_t seen, input reg8_t exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic reg8_t code(input int k);
    case (k)
      0: return {2'h3, `SRC_RX_READY_EVENT};
      1: return {2'h3, `SRC_MODEM};
      2, 4: return {2'h3, `SRC_XCHAR};
      default: return {2'h3, `SRC_PIN};
    endcase
  endfunction
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    r = $urandom(86);
    m = 8'h00;
    step(5);
    RESET <= 1'h0;
    step(1);
    #1;
    chk(MASK_RDATA, 8'h00);
    chk(SRC_RDATA, 8'h01);
    chk(IRQ, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom();
      step(1);
      ENH_EN <= i[0];
      HOST.acc(0, r);
      m = i[0] ? (r & 8'hEF) : {m[7:5], 1'h0, r[3:0]};
      step(1);
      #1;
      chk(MASK_RDATA, m);
    end
    $display("mask test done");
    r = $urandom();
    step(1);
    FIFO_EN <= 1'h1;
    HOST.acc(0, 8'h00);
    {RX_OVERRUN, RX_FIFO_ERR, TX_SHIFT_EMPTY, TX_HOLD_EMPTY, RX_TOP_ERR} <= r[6:0];
    RX_COUNT <= 7'h01;
    RX_PUSH <= 1'h1;
    step(1);
    RX_PUSH <= 1'h0;
    step(2);
    #1;
    chk(LINE_STATUS, {r[5], 2'h0, r[2:0], r[6], 1'h1});
    chk(IRQ, 8'h00);
    step(1);
    {RX_OVERRUN, RX_FIFO_ERR, TX_SHIFT_EMPTY, TX_HOLD_EMPTY, RX_TOP_ERR} <= 7'h00;
    RX_COUNT <= 7'h00;
    HOST.acc(2, 8'h00);
    HOST.acc(1, 8'h00);
    step(2);
    #1;
    chk(LINE_STATUS[0], 8'h00);
    $display("polled test done");
    step(1);
    HOST.acc(0, 8'h06);
    TX_COUNT <= 7'h03;
    RX_COUNT <= 7'h01;
    RX_PUSH <= 1'h1;
    RX_PUSH_ERR <= 1'h1;
    step(1);
    RX_PUSH <= 1'h0;
    RX_PUSH_ERR <= 1'h0;
    step(3);
    #1;
    chk(SRC_RDATA, {2'h3, `SRC_LINE});
    step(1);
    HOST.acc(2, 8'h00);
    step(2);
    #1;
    chk(SRC_RDATA, {2'h3, `SRC_TX_READY_EVENT});
    step(1);
    HOST.acc(1, 8'h00);
    RX_COUNT <= 7'h00;
    TX_COUNT <= 7'h04;
    step(2);
    #1;
    chk(SRC_RDATA, 8'hC1);
    $display("priority test done");
    step(1);
    HOST.acc(0, 8'h01);
    RX_COUNT <= 7'h02;
    RX_PUSH <= 1'h1;
    step(1);
    RX_PUSH <= 1'h0;
    tmo = (4 * int'(CHAR_BITS) + 12) * int'(BIT_CYCLES);
    step(tmo - 8);
    #1;
    chk(SRC_RDATA, 8'hC1);
    step(16);
    #1;
    chk(SRC_RDATA, {2'h3, `SRC_TIMEOUT});
    step(1);
    HOST.acc(4, 8'h00);
    RX_COUNT <= 7'h00;
    step(2);
    #1;
    chk(SRC_RDATA, 8'hC1);
    $display("timeout test done");
    for (int k = 0; k < 6; k++) begin
      r = $urandom_range(9, 2);
      step(1);
      HOST.acc(0, masks[k]);
      case (k)
        0: {RX_TRIGGER, RX_COUNT} <= {r[6:0], r[6:0]};
        1: MSR_DELTA <= $urandom_range(15, 1);
        2: XOFF_DET <= 1'h1;
        4: XON_DET <= 1'h1;
        5: {AUTO_RTS_EN, PIN_SEL_DTR, DTR_PIN} <= 3'h7;
        default: CTS_PIN <= 1'h1;
      endcase
      step(1);
      XOFF_DET <= 1'h0;
      XON_DET <= 1'h0;
      step(2);
      #1;
      chk(SRC_RDATA, code(k));
      chk(IRQ, 8'h01);
      step(1);
      case (k)
        0: RX_COUNT <= r[6:0] - 7'h01;
        1: MSR_DELTA <= 4'h0;
        default: ;
      endcase
      HOST.acc((k == 2 || k == 4) ? 1 : 3, 8'h00);
      step(3);
      #1;
      chk(SRC_RDATA, 8'hC1);
      step(1);
      RX_COUNT <= 7'h00;
    end
    $display("source table test done");
    step(1);
    WAKE_EVENT <= 1'h1;
    step(1);
    WAKE_EVENT <= 1'h0;
    step(1);
    #1;
    chk(WAKE_IND, 8'h01);
    step(1);
    HOST.acc(6, 8'h00);
    FIFO_EN <= 1'h0;
    step(2);
    #1;
    chk(WAKE_IND, 8'h00);
    chk(SRC_RDATA, 8'h01);
    $display("wake test done");
    step(1);
    HOST.acc(0, 8'h03);
    {HALF_DUPLEX_EN, TX_HOLD_EMPTY} <= 2'h3;
    step(3);
    #1;
    chk(SRC_RDATA, 8'h01);
    step(1);
    TX_SHIFT_EMPTY <= 1'h1;
    RX_HOLD_FULL <= 1'h1;
    step(3);
    #1;
    chk(SRC_RDATA, {2'h0, `SRC_RX_READY_EVENT});
    chk(LINE_STATUS, 8'h61);
    step(1);
    RX_HOLD_FULL <= 1'h0;
    step(3);
    #1;
    chk(SRC_RDATA, {2'h0, `SRC_TX_READY_EVENT});
    step(1);
    HOST.acc(5, 8'h00);
    step(2);
    #1;
    chk(SRC_RDATA, 8'h01);
    $display("non-FIFO test done");
    wrap_up();
  end
endmodule // uart_channel_interrupt_logic_tb_top
bind uart_channel_interrupt_logic uart_int_props u_props (.*);
`default_nettype wire
